// file: design/uat_core.sv
// serial transmitter and receiver with its registers
`timescale 1ns/1ps

module uat_core
   import uat_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic [15:0] addr_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   input  wire logic [7:0]  wdata_i,
   output logic      [7:0]  rdata_o,
   input  wire logic        serial_in_pin_i,
   output logic             serial_out_pin_o,
   output logic             rx_complete_irq_o,
   output logic             rx_error_irq_o,
   output logic             tx_complete_irq_o
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic par_of(input logic [7:0] d, input logic len8,
                                   input logic [1:0] sel);
      logic x;
      x = ^(len8 ? d : {1'b0, d[6:0]});
      unique case (sel)
         PAR_ODD:  par_of = ~x;
         PAR_EVEN: par_of = x;
         default:  par_of = 1'b0;
      endcase
   endfunction : par_of

   logic [7:0]        mode_r;
   logic [7:0]        txb_r;
   logic [7:0]        rxb_r;
   logic [2:0]        err_r;
   logic [7:0]        aux_r;
   logic              txbf_r;
   logic              txsf_r;
   logic              pending_r;
   logic              base_r;
   logic [1:0]        pwr_age_r;
   logic [2:0]        sync_r;
   logic              line_r;
   uat_ser_state_type tx_st_r;
   uat_ser_state_type rx_st_r;
   logic [7:0]        txs_r;
   logic              tx_par_r;
   logic [4:0]        tx_tick_r;
   logic [2:0]        tx_cnt_r;
   logic [7:0]        rxs_r;
   logic [4:0]        rx_tick_r;
   logic [2:0]        rx_cnt_r;
   logic              rx_pe_r;

   logic pwr, txe, rxe, len8, msbf, fall, tick_ok;
   logic tx_end, tx_load, rx_bit, rx_done, stop_ok;
   logic wr_txb, rd_rxb, rd_err;
   logic [1:0] par_sel;
   logic [2:0] last_bit;
   logic [7:0] rx_word;

   assign pwr      = mode_r[POWER_BIT];
   assign txe      = mode_r[TXE_BIT];
   assign rxe      = mode_r[RXE_BIT];
   assign len8     = mode_r[CLEN_BIT];
   assign par_sel  = mode_r[PAR_HI_BIT:PAR_LO_BIT];
   assign msbf     = aux_r[MSB_FIRST_BIT];
   assign last_bit = len8 ? 3'h7 : 3'h6;
   assign wr_txb   = wr_i && addr_i == TXB_ADDR;
   assign rd_rxb   = rd_i && addr_i == RXB_ADDR;
   assign rd_err   = rd_i && addr_i == ERR_ADDR;

   // ------------------------------------------------------------
   // base clock and power-up counter enable
   // ------------------------------------------------------------
   // the base clock is held low while power is off; all serial work
   // happens on its falling edge
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         base_r <= 1'b0;
      end else begin
         base_r <= pwr ? ~base_r : 1'b0;
      end
   end

   assign fall = base_r;

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pwr_age_r <= 2'h0;
      end else if (!pwr) begin
         pwr_age_r <= 2'h0;
      end else if (fall && pwr_age_r != PWR_WAIT) begin
         pwr_age_r <= pwr_age_r + 2'h1;
      end
   end

   assign tick_ok = fall && pwr_age_r == PWR_WAIT;

   // ------------------------------------------------------------
   // receive input synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync_r <= 3'h7;
         line_r <= 1'b1;
      end else begin
         sync_r <= {sync_r[1:0], serial_in_pin_i};
         if (!pwr) begin
            line_r <= 1'b1;
         end else if (sync_r[1] == sync_r[2]) begin
            line_r <= sync_r[2];
         end
      end
   end

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mode_r <= MODE_RST;
         aux_r  <= AUX_RST;
         txb_r  <= BUF_RST;
      end else if (wr_i) begin
         if (addr_i == MODE_ADDR) begin
            mode_r <= wdata_i;
         end
         if (addr_i == AUX_ADDR) begin
            aux_r <= wdata_i;
         end
         if (wr_txb) begin
            txb_r <= wdata_i;
         end
      end
   end

   // ------------------------------------------------------------
   // read port and transmit status
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         unique case (addr_i)
            MODE_ADDR: rdata_o <= mode_r;
            TXB_ADDR:  rdata_o <= txb_r;
            RXB_ADDR:  rdata_o <= rxb_r;
            ERR_ADDR:  rdata_o <= {5'h00, err_r};
            TXST_ADDR: rdata_o <= {6'h00, txbf_r, txsf_r};
            AUX_ADDR:  rdata_o <= aux_r;
            default:   rdata_o <= 8'h00;
         endcase
      end
   end

   // a write while full is the software's fault; the flag just stays set
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         txbf_r <= 1'b0;
      end else if (!pwr || !txe) begin
         txbf_r <= 1'b0;
      end else if (wr_txb) begin
         txbf_r <= 1'b1;
      end else if (tx_load) begin
         txbf_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // transmitter
   // ------------------------------------------------------------
   assign tx_end  = tx_st_r == SER_STOP && tx_tick_r == BIT_TICKS - 5'h1
                    && tx_cnt_r == {2'h0, mode_r[STOP_BIT]};
   assign tx_load = tick_ok && pwr && txe && txbf_r
                    && (tx_st_r == SER_IDLE || tx_end);

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_st_r           <= SER_IDLE;
         serial_out_pin_o  <= 1'b1;
         txsf_r            <= 1'b0;
         txs_r             <= BUF_RST;
         tx_par_r          <= 1'b0;
         tx_tick_r         <= 5'h00;
         tx_cnt_r          <= 3'h0;
         tx_complete_irq_o <= 1'b0;
      end else if (!pwr || !txe) begin
         tx_st_r           <= SER_IDLE;
         serial_out_pin_o  <= 1'b1;
         txsf_r            <= 1'b0;
         tx_tick_r         <= 5'h00;
         tx_cnt_r          <= 3'h0;
         tx_complete_irq_o <= 1'b0;
      end else begin
         tx_complete_irq_o <= tick_ok && tx_end;
         if (tx_load) begin
            // 7-bit msb-first is pre-shifted so data bit 6 is sent first
            txs_r    <= (msbf && !len8) ? {txb_r[6:0], 1'b0} : txb_r;
            tx_par_r <= par_of(txb_r, len8, par_sel);
            tx_st_r  <= SER_START;
            txsf_r   <= 1'b1;
            serial_out_pin_o <= 1'b0;
            tx_tick_r <= 5'h00;
         end else if (tick_ok && tx_st_r != SER_IDLE) begin
            tx_tick_r <= tx_tick_r + 5'h01;
            if (tx_tick_r == BIT_TICKS - 5'h1) begin
               tx_tick_r <= 5'h00;
               unique case (tx_st_r)
                  SER_START: begin
                     tx_st_r  <= SER_DATA;
                     tx_cnt_r <= 3'h0;
                     serial_out_pin_o <= msbf ? txs_r[7] : txs_r[0];
                     txs_r <= msbf ? {txs_r[6:0], 1'b1} : {1'b1, txs_r[7:1]};
                  end
                  SER_DATA: begin
                     tx_cnt_r <= tx_cnt_r + 3'h1;
                     serial_out_pin_o <= msbf ? txs_r[7] : txs_r[0];
                     txs_r <= msbf ? {txs_r[6:0], 1'b1} : {1'b1, txs_r[7:1]};
                     if (tx_cnt_r == last_bit) begin
                        tx_cnt_r <= 3'h0;
                        if (par_sel != PAR_NONE) begin
                           tx_st_r <= SER_PAR;
                           serial_out_pin_o <= tx_par_r;
                        end else begin
                           tx_st_r <= SER_STOP;
                           serial_out_pin_o <= 1'b1;
                        end
                     end
                  end
                  SER_PAR: begin
                     tx_st_r <= SER_STOP;
                     serial_out_pin_o <= 1'b1;
                  end
                  SER_STOP: begin
                     if (tx_end) begin
                        tx_st_r <= SER_IDLE;
                        txsf_r  <= 1'b0;
                     end else begin
                        tx_cnt_r <= tx_cnt_r + 3'h1;
                     end
                  end
                  SER_IDLE: tx_st_r <= SER_IDLE;
               endcase
            end
         end
      end
   end

   // ------------------------------------------------------------
   // receiver sequencing
   // ------------------------------------------------------------
   assign rx_bit  = tick_ok && rx_tick_r == BIT_TICKS - 5'h1;
   assign rx_done = rx_bit && rx_st_r == SER_STOP;
   assign stop_ok = line_r;                  // one stop bit only
   // 7-bit lsb-first lands in bits 7..1, msb-first in 6..0
   assign rx_word = len8 ? rxs_r
                    : (msbf ? {rxs_r[6:0], 1'b0}
                            : {1'b0, rxs_r[7:1]});

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_st_r   <= SER_IDLE;
         rxs_r     <= BUF_RST;
         rx_tick_r <= 5'h00;
         rx_cnt_r  <= 3'h0;
         rx_pe_r   <= 1'b0;
      end else if (!pwr || !rxe) begin
         rx_st_r   <= SER_IDLE;
         rx_tick_r <= 5'h00;
         rx_cnt_r  <= 3'h0;
         rx_pe_r   <= 1'b0;
      end else if (tick_ok) begin
         rx_tick_r <= rx_tick_r + 5'h01;
         unique case (rx_st_r)
            SER_IDLE: begin
               rx_tick_r <= 5'h00;
               rx_pe_r   <= 1'b0;
               if (!line_r) begin
                  rx_st_r <= SER_START;
               end
            end
            SER_START: begin
               if (rx_tick_r == HALF_TICKS - 5'h1) begin
                  rx_tick_r <= 5'h00;
                  rx_cnt_r  <= 3'h0;
                  rx_st_r   <= line_r ? SER_IDLE : SER_DATA;
               end
            end
            SER_DATA: begin
               if (rx_bit) begin
                  rx_tick_r <= 5'h00;
                  rx_cnt_r  <= rx_cnt_r + 3'h1;
                  rxs_r <= msbf ? {rxs_r[6:0], line_r}
                                : {line_r, rxs_r[7:1]};
                  if (rx_cnt_r == last_bit) begin
                     rx_st_r <= (par_sel != PAR_NONE) ? SER_PAR
                                                      : SER_STOP;
                  end
               end
            end
            SER_PAR: begin
               if (rx_bit) begin
                  rx_tick_r <= 5'h00;
                  rx_st_r   <= SER_STOP;
                  // zero-parity mode is never judged
                  // undo the msb-first 7-bit shift so data bit 6 counts
                  rx_pe_r <= par_sel != PAR_ZERO
                             && line_r != par_of((msbf && !len8)
                                ? {1'b0, rx_word[7:1]} : rx_word,
                                len8, par_sel);
               end
            end
            SER_STOP: begin
               if (rx_bit) begin
                  rx_tick_r <= 5'h00;
                  rx_st_r   <= SER_IDLE;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // receive buffer, error flags and receive interrupts
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rxb_r     <= BUF_RST;
         pending_r <= 1'b0;
      end else if (!pwr) begin
         rxb_r     <= BUF_RST;
         pending_r <= 1'b0;
      end else if (rx_done && pwr && rxe && !pending_r) begin
         rxb_r     <= rx_word;
         pending_r <= 1'b1;
      end else if (rd_rxb || !rxe) begin
         pending_r <= 1'b0;
      end
   end

   // a flag raised in the cycle of a status read survives the read
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         err_r <= ERR_RST;
      end else if (!pwr || !rxe) begin
         err_r <= ERR_RST;
      end else begin
         err_r <= (rd_err ? 3'h0 : err_r)
                  | (rx_done ? {rx_pe_r, !stop_ok,
                                pending_r} : 3'h0);
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_complete_irq_o <= 1'b0;
         rx_error_irq_o    <= 1'b0;
      end else begin
         rx_complete_irq_o <= rx_done && rxe && (mode_r[ROUTE_BIT] ||
                              !(rx_pe_r || !stop_ok || pending_r));
         rx_error_irq_o    <= rx_done && rxe && !mode_r[ROUTE_BIT] &&
                              (rx_pe_r || !stop_ok || pending_r);
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);

   power_off_pin_a: assert property (!pwr |=> serial_out_pin_o)
      else $error("output not high with power off");
   power_off_rxb_a: assert property (!pwr |=> rxb_r == BUF_RST)
      else $error("receive buffer not reset with power off");
   rx_off_err_a: assert property (!rxe |=> err_r == 3'h0)
      else $error("error flags kept with receive disabled");
   load_clears_full_a: assert property (tx_load && !wr_txb
      |=> !txbf_r && txsf_r && !serial_out_pin_o)
      else $error("load did not clear full flag or drive start");
   write_sets_full_a: assert property (wr_txb && pwr && txe
      && $past(pwr) ##1 (pwr && txe) |-> txbf_r)
      else $error("write did not set full flag");
   overrun_hold_a: assert property (rx_done && pending_r && pwr
      |=> $stable(rxb_r) && err_r[OVE_BIT])
      else $error("overrun changed buffer or missed flag");
   zero_par_a: assert property (par_sel == PAR_ZERO
      && $stable(par_sel) && rx_done |-> !rx_pe_r)
      else $error("parity flagged in zero parity mode");
   route_irq_a: assert property (rx_done && rxe && mode_r[ROUTE_BIT]
      |=> rx_complete_irq_o && !rx_error_irq_o)
      else $error("routing bit did not select complete");
   start_wait_a: assert property ($rose(pwr) |-> !tick_ok [*3])
      else $error("counter ran before second base clock");
   tx_fall_a: assert property (tx_load |-> base_r)
      else $error("load off the base falling edge");

   tx_frame_c:   cover property (tx_complete_irq_o);
   rx_ok_c:      cover property (rx_complete_irq_o && err_r == 3'h0);
   rx_err_c:     cover property (rx_error_irq_o);
   tx_cont_c:    cover property (tx_load && tx_st_r == SER_STOP);
endmodule : uat_core

// file: design/uat_pkg.sv
// package: register map, field positions and timing of the serial unit
package uat_pkg;
   // ------------------------------------------------------------
   // register addresses
   // ------------------------------------------------------------
   localparam logic [15:0] MODE_ADDR    = 16'hFF50;
   localparam logic [15:0] TXB_ADDR     = 16'hFF51;
   localparam logic [15:0] RXB_ADDR     = 16'hFF52;
   localparam logic [15:0] ERR_ADDR     = 16'hFF53;
   localparam logic [15:0] TXST_ADDR    = 16'hFF55;
   localparam logic [15:0] AUX_ADDR     = 16'hFF57;
   // ------------------------------------------------------------
   // serial_mode_control fields
   // ------------------------------------------------------------
   localparam int POWER_BIT    = 7;
   localparam int TXE_BIT      = 6;
   localparam int RXE_BIT      = 5;
   localparam int PAR_HI_BIT   = 4;
   localparam int PAR_LO_BIT   = 3;
   localparam int CLEN_BIT     = 2;
   localparam int STOP_BIT     = 1;
   localparam int ROUTE_BIT    = 0;
   // receive_error_status, transmit_status, aux control fields
   localparam int PE_BIT       = 2;
   localparam int FE_BIT       = 1;
   localparam int OVE_BIT      = 0;
   localparam int TXBF_BIT     = 1;
   localparam int TXSF_BIT     = 0;
   localparam int MSB_FIRST_BIT = 0;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] MODE_RST  = 8'h01;
   localparam logic [7:0] BUF_RST   = 8'hFF;
   localparam logic [2:0] ERR_RST   = 3'h0;
   localparam logic [7:0] AUX_RST   = 8'h00;
   // parity modes
   localparam logic [1:0] PAR_NONE  = 2'h0;
   localparam logic [1:0] PAR_ZERO  = 2'h1;
   localparam logic [1:0] PAR_ODD   = 2'h2;
   localparam logic [1:0] PAR_EVEN  = 2'h3;
   // ------------------------------------------------------------
   // timing: base clock periods per bit, counter enable delay
   // ------------------------------------------------------------
   localparam logic [4:0] BIT_TICKS  = 5'h10;
   localparam logic [4:0] HALF_TICKS = 5'h08;
   localparam logic [1:0] PWR_WAIT   = 2'h2;

   typedef enum logic [2:0] {
      SER_IDLE, SER_START, SER_DATA, SER_PAR, SER_STOP
   } uat_ser_state_type;
endpackage : uat_pkg

// file: verification/uat_core_test.sv
// self-checking bench for the serial unit facing a remote node
`timescale 1ns/1ps
module uat_core_test
   import uat_pkg::*;
;
   typedef struct {
      logic [7:0] mode, aux, d, rxb, err;
      int         n;
      logic       bp, bs;
   } uat_row_type;
   logic        sys_clk, reset_n, wr, rd, sin, sout, rxc, rxe, txc, ee;
   logic [15:0] addr;
   logic [7:0]  wdata, rdata, v, f1, f2;
   logic        p1, p2;
   logic [1:0]  s1, s2;
   int          miscompares = 0, n_checks = 0;
   int          nrc = 0, nre = 0, ntc = 0, c0, e0;
   uat_row_type rows [8] = '{
      '{8'hA4, 8'h00, 8'hA5, 8'hA5, 8'h00, 8, 1'b0, 1'b0},
      '{8'hB8, 8'h00, 8'h35, 8'h35, 8'h00, 7, 1'b0, 1'b0},
      '{8'hB8, 8'h01, 8'h55, 8'hAA, 8'h00, 7, 1'b0, 1'b0},
      '{8'hB4, 8'h00, 8'h3C, 8'h3C, 8'h00, 8, 1'b0, 1'b0},
      '{8'hAC, 8'h00, 8'h0F, 8'h0F, 8'h00, 8, 1'b1, 1'b0},
      '{8'hBC, 8'h00, 8'h0F, 8'h0F, 8'h04, 8, 1'b1, 1'b0},
      '{8'hBD, 8'h00, 8'h0F, 8'h0F, 8'h04, 8, 1'b1, 1'b0},
      '{8'hA4, 8'h00, 8'h5E, 8'h5E, 8'h02, 8, 1'b0, 1'b1}};

   uat_core uat_core_inst (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
      .addr_i(addr), .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata),
      .serial_in_pin_i(sin), .serial_out_pin_o(sout),
      .rx_complete_irq_o(rxc), .rx_error_irq_o(rxe), .tx_complete_irq_o(txc));
   uat_remote uat_remote_inst (.line_i(sout), .line_o(sin));

   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (rxc === 1'b1) nrc++;
      if (rxe === 1'b1) nre++;
      if (txc === 1'b1) ntc++;
   end

   // ------------------------------------------------------------
   // register access and comparison
   // ------------------------------------------------------------
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge sys_clk);
      wr = 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      addr = a;
      rd = 1'b1;
      @(negedge sys_clk);
      rd = 1'b0;
      d = rdata;
   endtask : rd_reg

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_rd(input logic [15:0] a, input logic [7:0] exp);
      rd_reg(a, v);
      chk(v, exp);
   endtask : chk_rd

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude

   // a full run takes about 0.1 ms; allow five times that
   initial begin
      #500_000;
      miscompares++;
      conclude();
   end

   initial begin
      sys_clk = 1'b0;
      reset_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 16'h0000;
      wdata = 8'h00;
      repeat (20) @(negedge sys_clk);
      reset_n = 1'b1;
      chk_rd(MODE_ADDR, MODE_RST);
      chk_rd(TXB_ADDR, BUF_RST);
      chk_rd(ERR_ADDR, 8'h00);
      wr_reg(RXB_ADDR, 8'h12);
      chk_rd(RXB_ADDR, BUF_RST);
      chk_rd(16'hFF5F, 8'h00);
      $display("reset test done");
      foreach (rows[i]) begin
         wr_reg(MODE_ADDR, 8'h80);
         wr_reg(AUX_ADDR, rows[i].aux);
         wr_reg(MODE_ADDR, rows[i].mode);
         c0 = nrc;
         e0 = nre;
         uat_remote_inst.send(rows[i].d, rows[i].n, rows[i].aux[0],
            rows[i].mode[4:3], rows[i].bp, rows[i].bs);
         repeat (40) @(negedge sys_clk);
         ee = (rows[i].err != 8'h00) && !rows[i].mode[ROUTE_BIT];
         chk_rd(RXB_ADDR, rows[i].rxb);
         chk_rd(ERR_ADDR, rows[i].err);
         chk(8'(nre - e0), {7'h00, ee});
         chk(8'(nrc - c0), {7'h00, ~ee});
      end
      $display("receive table done");
      wr_reg(MODE_ADDR, 8'h80);
      wr_reg(AUX_ADDR, 8'h00);
      wr_reg(MODE_ADDR, 8'hA6);
      uat_remote_inst.send(8'h11, 8, 1'b0, 2'h0, 1'b0, 1'b0);
      uat_remote_inst.send(8'h22, 8, 1'b0, 2'h0, 1'b0, 1'b0);
      repeat (40) @(negedge sys_clk);
      chk_rd(ERR_ADDR, 8'h01);
      chk_rd(ERR_ADDR, 8'h00);
      chk_rd(RXB_ADDR, 8'h11);
      $display("overrun test done");
      wr_reg(MODE_ADDR, 8'h80);
      wr_reg(MODE_ADDR, 8'hDE);
      fork
         begin
            uat_remote_inst.capture(8, 1'b1, f1, p1, s1);
            uat_remote_inst.capture(8, 1'b1, f2, p2, s2);
         end
      join_none
      wr_reg(TXB_ADDR, 8'h97);
      chk_rd(TXB_ADDR, 8'h97);
      v = 8'hFF;
      for (int k = 0; k < 20 && v[TXBF_BIT] !== 1'b0; k++) begin
         rd_reg(TXST_ADDR, v);
      end
      chk(v & 8'h03, 8'h01);
      wr_reg(TXB_ADDR, 8'h5A);
      wait fork;
      repeat (40) @(negedge sys_clk);
      chk(f1, 8'h97);
      chk(f2, 8'h5A);
      chk({4'h0, s1, s2}, 8'h0F);
      chk({6'h00, p1, p2}, 8'h02);
      chk(8'(ntc), 8'h02);
      chk_rd(TXST_ADDR, 8'h00);
      $display("transmit test done");
      wr_reg(MODE_ADDR, 8'h80);
      wr_reg(MODE_ADDR, 8'h00);
      chk_rd(RXB_ADDR, BUF_RST);
      chk({7'h00, sout}, 8'h01);
      $display("power test done");
      conclude();
   end
endmodule : uat_core_test

// file: verification/uat_remote.sv
// remote serial node model: sends frames to the unit and captures its frames
`timescale 1ns/1ps
module uat_remote #(
   parameter int BIT_NS = 640
) (
   input  wire logic line_i,
   output logic      line_o
);
   // the line idles high between frames, as a pulled-up line would
   initial line_o = 1'b1;

   function automatic logic par_of(input logic [7:0] d, input logic [1:0] pm);
      if (pm == 2'h2) begin
         return ~^d;
      end
      if (pm == 2'h3) begin
         return ^d;
      end
      return 1'b0;
   endfunction : par_of

   // bp and bs break the parity and the stop bit on purpose
   task automatic send(input logic [7:0] d, input int n, input logic msb,
                       input logic [1:0] pm, input logic bp, input logic bs);
      logic p;
      p = par_of(d, pm) ^ bp;
      line_o = 1'b0;
      #BIT_NS;
      for (int i = 0; i < n; i++) begin
         line_o = msb ? d[n-1-i] : d[i];
         #BIT_NS;
      end
      if (pm != 2'h0) begin
         line_o = p;
         #BIT_NS;
      end
      line_o = ~bs;
      #BIT_NS;
      line_o = 1'b1;
   endtask : send

   // samples at bit centres, lsb first, two stop levels
   task automatic capture(input int n, input logic hp, output logic [7:0] d,
                          output logic p, output logic [1:0] st);
      d = 8'h00;
      p = 1'b0;
      wait (line_i === 1'b0);
      #(BIT_NS / 2);
      for (int i = 0; i < n; i++) begin
         #BIT_NS;
         d[i] = line_i;
      end
      if (hp) begin
         #BIT_NS;
         p = line_i;
      end
      #BIT_NS;
      st[0] = line_i;
      #BIT_NS;
      st[1] = line_i;
   endtask : capture
endmodule : uat_remote
